// ---- timer16_defines.svh ----
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH
// ****************************************************************
// Register addresses on the I/O bus
// ****************************************************************
`define ADDR_CMPB_LO 6'h28
`define ADDR_CMPB_HI 6'h29
`define ADDR_CMPA_LO 6'h2A
`define ADDR_CMPA_HI 6'h2B
`define ADDR_CNT_LO  6'h2C
`define ADDR_CNT_HI  6'h2D
`define ADDR_CTRLB   6'h2E
// ****************************************************************
// Control register B fields and reset values
// ****************************************************************
`define CTRLB_FILT   7
`define CTRLB_EDGE   6
`define CTRLB_RES_HI 5
`define CTRLB_RES_LO 4
`define CTRLB_CTC    3
`define CTRLB_CS_HI  2
`define CTRLB_CS_LO  0
`define RESET_BYTE   8'h00
`define RESET_WORD   16'h0000
// ****************************************************************
// Clock select codes and prescaler masks
// ****************************************************************
`define CS_STOP      3'h0
`define CS_DIV1      3'h1
`define CS_DIV8      3'h2
`define CS_DIV64     3'h3
`define CS_DIV256    3'h4
`define CS_DIV1024   3'h5
`define CS_EXT_FALL  3'h6
`define CS_EXT_RISE  3'h7
`define PRE_M8       10'h007
`define PRE_M64      10'h03F
`define PRE_M256     10'h0FF
`define PRE_M1024    10'h3FF
// ****************************************************************
// Waveform tops and filter depth
// ****************************************************************
`define PWM_OFF      2'h0
`define PWM_8        2'h1
`define PWM_9        2'h2
`define TOP_8        16'h00FF
`define TOP_9        16'h01FF
`define TOP_10       16'h03FF
`define FILT_DEPTH   4
`endif

// ---- timer16_pkg.sv ----
`default_nettype none
package timer16_pkg;
   typedef struct packed {
      logic [9:0] div;
      logic [1:0] extSync;
      logic       extPrev;
      logic       tick;
   } presc_s;

   typedef struct packed {
      logic [1:0] pinSync;
      logic [3:0] hist;
      logic       level;
      logic       trig;
   } filt_s;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] cmpA;
      logic [15:0] cmpB;
      logic [7:0]  temp;
      logic        filt;
      logic        edgeSel;
      logic        ctc;
      logic [2:0]  cs;
      logic [7:0]  rdData;
      logic        counted;
      logic        down;
      logic        hitA;
      logic        hitB;
      logic        flagA;
      logic        flagB;
      logic [15:0] capVal;
      logic        capFlag;
   } core_s;
endpackage
`default_nettype wire

// ---- timer16_prescaler.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "timer16_defines.svh"
module timer16_prescaler
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Source select and external pin
   input  wire logic [2:0] clockSelect,
   input  wire logic       extPin,
   // Timer clock enable
   output logic            tick
);
   timer16_pkg::presc_s st_r;
   timer16_pkg::presc_s st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.div = st_r.div + 10'h001;
      st_nxt.extSync = {st_r.extSync[0], extPin};
      st_nxt.extPrev = st_r.extSync[1];
      case (clockSelect)
         `CS_STOP:     st_nxt.tick = 1'b0;
         `CS_DIV1:     st_nxt.tick = 1'b1;
         `CS_DIV8:     st_nxt.tick = (st_r.div & `PRE_M8) == `PRE_M8;
         `CS_DIV64:    st_nxt.tick = (st_r.div & `PRE_M64) == `PRE_M64;
         `CS_DIV256:   st_nxt.tick = (st_r.div & `PRE_M256) == `PRE_M256;
         `CS_DIV1024:  st_nxt.tick = st_r.div == `PRE_M1024;
         `CS_EXT_FALL: st_nxt.tick = st_r.extPrev & ~st_r.extSync[1];
         default:      st_nxt.tick = ~st_r.extPrev & st_r.extSync[1];
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign tick = st_r.tick;
endmodule
`default_nettype wire

// ---- timer16_capture_filter.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "timer16_defines.svh"
module timer16_capture_filter
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Settings
   input  wire logic filterEnable,
   input  wire logic edgeSelect,
   // Capture pin and trigger
   input  wire logic capturePin,
   output logic      trigger
);
   timer16_pkg::filt_s st_r;
   timer16_pkg::filt_s st_nxt;
   logic               agree;

   // Pin sampled every clock, which is the crystal rate
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.pinSync = {st_r.pinSync[0], capturePin};
      st_nxt.hist = {st_r.hist[2:0], st_r.pinSync[1]};
      agree = filterEnable ? (&st_nxt.hist | ~|st_nxt.hist) : 1'b1;
      st_nxt.trig = 1'b0;
      if (agree && st_nxt.hist[0] != st_r.level)
      begin
         st_nxt.level = st_nxt.hist[0];
         st_nxt.trig = st_nxt.hist[0] == edgeSelect;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign trigger = st_r.trig;

   filter_samples_a: assert property (@(posedge clk) disable iff (!rstn)
      st_r.trig && $past(filterEnable) |-> st_r.hist == {`FILT_DEPTH{$past(edgeSelect)}})
      else $error("capture taken without four agreeing samples");
endmodule
`default_nettype wire

// ---- timer16_capture_compare_core.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "timer16_defines.svh"
// Summary of operation
// - Filter off: first sampled edge captures
// - Filter on: four agreeing samples before capture
// - Capture pin sampled every crystal clock
// - Edge select: zero falling, one rising
// - Control bits five and four read zero
// - Clear-on-compare: counter zeroed after match A
// - Clear bit off: matches never touch counter
// - Match seen one CPU cycle late
// - Waveform mode ignores the clear bit
// - Clock select: stop or prescaled core clock
// - Codes six, seven: external pin edges
// - High byte parked; low write loads all
// - Low read parks high byte for later
// - Counting resumes from written value next tick
// - Only counting, never writes, makes matches
// - Compare flag set cycle after match
// - Compare high byte parked until low write
// - Capture flag set with capture load
module timer16_capture_compare_core
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // I/O bus from the CPU core
   input  wire logic [5:0]  ioAddr,
   input  wire logic [7:0]  ioWrData,
   input  wire logic        ioWr,
   input  wire logic        ioRd,
   output logic      [7:0]  ioRdData,
   // Waveform mode from control register A
   input  wire logic [1:0]  pwmSelect,
   // Pins
   input  wire logic        capturePin,
   input  wire logic        externalCountPin,
   // Events and captured value
   output logic             compareAFlag,
   output logic             compareBFlag,
   output logic             captureFlag,
   output logic      [15:0] captureValue
);
   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic [1:0] rstSync;
   logic       rstnInt;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rstSync <= 2'b00;
      else
         rstSync <= {rstSync[0], 1'b1};
   end

   assign rstnInt = rstSync[1];

   // ****************************************************************
   // Timer clock and capture trigger
   // ****************************************************************
   timer16_pkg::core_s st_r;
   timer16_pkg::core_s st_nxt;
   logic               tick;
   logic               capTrig;

   timer16_prescaler u_prescaler
   (
      .clk         (clk),
      .rstn        (rstnInt),
      .clockSelect (st_r.cs),
      .extPin      (externalCountPin),
      .tick        (tick)
   );

   timer16_capture_filter u_filter
   (
      .clk          (clk),
      .rstn         (rstnInt),
      .filterEnable (st_r.filt),
      .edgeSelect   (st_r.edgeSel),
      .capturePin   (capturePin),
      .trigger      (capTrig)
   );

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   logic        cntWrite;
   logic        cntLoRead;
   logic        pwmOn;
   logic [15:0] top;
   logic [15:0] cntCount;

   assign cntWrite  = ioWr && ioAddr == `ADDR_CNT_LO;
   assign cntLoRead = ioRd && ioAddr == `ADDR_CNT_LO;
   assign pwmOn     = pwmSelect != `PWM_OFF;

   always_comb
   begin
      if (pwmSelect == `PWM_8)
         top = `TOP_8;
      else if (pwmSelect == `PWM_9)
         top = `TOP_9;
      else
         top = `TOP_10;
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      st_nxt = st_r;
      cntCount = st_r.cnt;
      st_nxt.hitA = 1'b0;
      st_nxt.hitB = 1'b0;
      st_nxt.capFlag = 1'b0;
      st_nxt.flagA = st_r.hitA;
      st_nxt.flagB = st_r.hitB;

      // Counter: a write wins over a tick in the same cycle
      if (cntWrite)
      begin
         st_nxt.cnt = {st_r.temp, ioWrData};
         st_nxt.counted = 1'b0;
      end
      else if (tick)
      begin
         if (pwmOn)
         begin
            if (!st_r.down && st_r.cnt >= top)
            begin
               st_nxt.down = 1'b1;
               cntCount = st_r.cnt - 16'h0001;
            end
            else if (st_r.down && st_r.cnt == `RESET_WORD)
            begin
               st_nxt.down = 1'b0;
               cntCount = st_r.cnt + 16'h0001;
            end
            else if (st_r.down)
               cntCount = st_r.cnt - 16'h0001;
            else
               cntCount = st_r.cnt + 16'h0001;
         end
         else if (st_r.ctc && st_r.counted && st_r.cnt == st_r.cmpA)
            cntCount = `RESET_WORD;
         else
            cntCount = st_r.cnt + 16'h0001;
         st_nxt.cnt = cntCount;
         st_nxt.counted = 1'b1;
         st_nxt.hitA = cntCount == st_r.cmpA;
         st_nxt.hitB = cntCount == st_r.cmpB;
      end
      if (!pwmOn)
         st_nxt.down = 1'b0;

      // Capture loads the value and raises the flag together
      if (capTrig)
      begin
         st_nxt.capVal = st_r.cnt;
         st_nxt.capFlag = 1'b1;
      end

      // Register writes
      if (ioWr)
      begin
         if (ioAddr == `ADDR_CNT_HI || ioAddr == `ADDR_CMPA_HI || ioAddr == `ADDR_CMPB_HI)
            st_nxt.temp = ioWrData;
         else if (ioAddr == `ADDR_CMPA_LO)
            st_nxt.cmpA = {st_r.temp, ioWrData};
         else if (ioAddr == `ADDR_CMPB_LO)
            st_nxt.cmpB = {st_r.temp, ioWrData};
         else if (ioAddr == `ADDR_CTRLB)
         begin
            st_nxt.filt = ioWrData[`CTRLB_FILT];
            st_nxt.edgeSel = ioWrData[`CTRLB_EDGE];
            st_nxt.ctc = ioWrData[`CTRLB_CTC];
            st_nxt.cs = ioWrData[`CTRLB_CS_HI:`CTRLB_CS_LO];
         end
      end

      // Register reads, answered one cycle after the strobe
      st_nxt.rdData = `RESET_BYTE;
      if (ioRd)
      begin
         if (ioAddr == `ADDR_CNT_LO)
         begin
            st_nxt.rdData = st_r.cnt[7:0];
            st_nxt.temp = st_r.cnt[15:8];
         end
         else if (ioAddr == `ADDR_CNT_HI)
            st_nxt.rdData = st_r.temp;
         else if (ioAddr == `ADDR_CMPA_LO)
            st_nxt.rdData = st_r.cmpA[7:0];
         else if (ioAddr == `ADDR_CMPA_HI)
            st_nxt.rdData = st_r.cmpA[15:8];
         else if (ioAddr == `ADDR_CMPB_LO)
            st_nxt.rdData = st_r.cmpB[7:0];
         else if (ioAddr == `ADDR_CMPB_HI)
            st_nxt.rdData = st_r.cmpB[15:8];
         else if (ioAddr == `ADDR_CTRLB)
            st_nxt.rdData = {st_r.filt, st_r.edgeSel, 2'b00, st_r.ctc, st_r.cs};
      end
   end

   always_ff @(posedge clk or negedge rstnInt)
   begin
      if (!rstnInt)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign ioRdData     = st_r.rdData;
   assign compareAFlag = st_r.flagA;
   assign compareBFlag = st_r.flagB;
   assign captureFlag  = st_r.capFlag;
   assign captureValue = st_r.capVal;

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence sCountStep;
      tick && !cntWrite && !pwmOn;
   endsequence

   sequence sReadLowThenHigh;
      cntLoRead ##1 (ioRd && ioAddr == `ADDR_CNT_HI);
   endsequence

   capture_load_a: assert property (@(posedge clk) disable iff (!rstnInt)
      capTrig |=> captureFlag && captureValue == $past(st_r.cnt))
      else $error("capture value or flag wrong");

   reserved_bits_a: assert property (@(posedge clk) disable iff (!rstnInt)
      ioRd && ioAddr == `ADDR_CTRLB |=> ioRdData[`CTRLB_RES_HI:`CTRLB_RES_LO] == 2'b00)
      else $error("reserved control bits not zero");

   ctc_clear_a: assert property (@(posedge clk) disable iff (!rstnInt)
      sCountStep ##0 (st_r.ctc && st_r.counted && st_r.cnt == st_r.cmpA) |=> st_r.cnt == 16'h0000)
      else $error("counter not cleared after compare A");

   free_count_a: assert property (@(posedge clk) disable iff (!rstnInt)
      sCountStep ##0 !st_r.ctc |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
      else $error("counter disturbed with clear bit off");

   stopped_hold_a: assert property (@(posedge clk) disable iff (!rstnInt)
      st_r.cs == `CS_STOP && $past(st_r.cs) == `CS_STOP && !cntWrite |=> $stable(st_r.cnt))
      else $error("counter moved while stopped");

   write_nomatch_a: assert property (@(posedge clk) disable iff (!rstnInt)
      cntWrite |=> !st_r.hitA ##1 !compareAFlag)
      else $error("counter write produced a match");

   match_flag_a: assert property (@(posedge clk) disable iff (!rstnInt)
      sCountStep ##0 (st_r.cnt + 16'h0001 == st_r.cmpA && !st_r.ctc) |=> ##1 compareAFlag)
      else $error("compare A flag not one cycle after match");

   count_write_a: assert property (@(posedge clk) disable iff (!rstnInt)
      cntWrite |=> st_r.cnt == {$past(st_r.temp), $past(ioWrData)})
      else $error("counter write not 16 bits at once");

   read_pair_a: assert property (@(posedge clk) disable iff (!rstnInt)
      sReadLowThenHigh |=> ioRdData == $past(st_r.cnt[15:8], 2))
      else $error("high byte read not from parked byte");

   compare_write_a: assert property (@(posedge clk) disable iff (!rstnInt)
      ioWr && ioAddr == `ADDR_CMPA_LO |=> st_r.cmpA == {$past(st_r.temp), $past(ioWrData)})
      else $error("compare A not written as a pair");

   // ****************************************************************
   // Checks on compare B, waveform counting, the shared byte, counter hold, capture and control register B
   // ****************************************************************
   sequence sWaveStep;
      tick && !cntWrite && pwmOn;
   endsequence

   sequence sWriteThenCount;
      cntWrite ##1 (tick && !cntWrite && !pwmOn && !st_r.ctc);
   endsequence

   compare_b_write_a: assert property (@(posedge clk) disable iff (!rstnInt)
      ioWr && ioAddr == `ADDR_CMPB_LO |=> st_r.cmpB == {$past(st_r.temp), $past(ioWrData)})
      else $error("compare B not written as a pair");

   temp_park_a: assert property (@(posedge clk) disable iff (!rstnInt)
      ioWr && (ioAddr == `ADDR_CNT_HI || ioAddr == `ADDR_CMPA_HI || ioAddr == `ADDR_CMPB_HI)
      |=> st_r.temp == $past(ioWrData))
      else $error("high byte not parked in shared byte");

   low_read_park_a: assert property (@(posedge clk) disable iff (!rstnInt)
      cntLoRead |=> ioRdData == $past(st_r.cnt[7:0]) && st_r.temp == $past(st_r.cnt[15:8]))
      else $error("low read did not park the high byte");

   resume_count_a: assert property (@(posedge clk) disable iff (!rstnInt)
      sWriteThenCount |=> st_r.cnt == {$past(st_r.temp, 2), $past(ioWrData, 2)} + 16'h0001)
      else $error("counting did not resume from written value");

   hold_between_a: assert property (@(posedge clk) disable iff (!rstnInt)
      !tick && !cntWrite |=> $stable(st_r.cnt))
      else $error("counter moved without a timer tick");

   wave_no_clear_a: assert property (@(posedge clk) disable iff (!rstnInt)
      sWaveStep ##0 (!st_r.down && st_r.cnt < top)
      |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
      else $error("waveform count disturbed by clear bit");

   wave_turn_a: assert property (@(posedge clk) disable iff (!rstnInt)
      sWaveStep ##0 (!st_r.down && st_r.cnt >= top)
      |=> st_r.down && st_r.cnt == $past(st_r.cnt) - 16'h0001)
      else $error("waveform count did not turn at top");

   wave_bottom_a: assert property (@(posedge clk) disable iff (!rstnInt)
      sWaveStep ##0 (st_r.down && st_r.cnt == `RESET_WORD)
      |=> !st_r.down && st_r.cnt == 16'h0001)
      else $error("waveform count did not turn at zero");

   match_b_flag_a: assert property (@(posedge clk) disable iff (!rstnInt)
      sCountStep ##0 (st_r.cnt + 16'h0001 == st_r.cmpB && !st_r.ctc) |=> ##1 compareBFlag)
      else $error("compare B flag not one cycle after match");

   count_only_match_a: assert property (@(posedge clk) disable iff (!rstnInt)
      compareAFlag || compareBFlag |-> $past(tick, 2) && !$past(cntWrite, 2))
      else $error("compare flag without a counting step");

   capture_cause_a: assert property (@(posedge clk) disable iff (!rstnInt)
      captureFlag |-> $past(capTrig))
      else $error("capture flag without a trigger");

   control_write_a: assert property (@(posedge clk) disable iff (!rstnInt)
      ioWr && ioAddr == `ADDR_CTRLB |=> st_r.cs == $past(ioWrData[`CTRLB_CS_HI:`CTRLB_CS_LO])
         && st_r.ctc == $past(ioWrData[`CTRLB_CTC]))
      else $error("control register B not written");
endmodule
`default_nettype wire

// ---- timer16_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// CPU side of the I/O bus: one access per wr or rd call, two per wr16 or rd16, no interrupt code
// ****************************************************************
module timer16_cpu_model
(
   // Clock
   input  wire logic       clk,
   // I/O bus
   output logic      [5:0] ioAddr,
   output logic      [7:0] ioWrData,
   output logic            ioWr,
   output logic            ioRd,
   input  wire logic [7:0] ioRdData
);
   initial
   begin
      ioAddr = 6'h00;
      ioWrData = 8'h00;
      ioWr = 1'b0;
      ioRd = 1'b0;
   end

   // Released lines show inverted values so stale data cannot pass
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      ioAddr <= a;
      ioWrData <= d;
      ioWr <= 1'b1;
      @(posedge clk);
      ioWr <= 1'b0;
      ioAddr <= ~a;
      ioWrData <= ~d;
   endtask

   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      ioAddr <= a;
      ioRd <= 1'b1;
      @(posedge clk);
      ioRd <= 1'b0;
      ioAddr <= ~a;
      // Reply stands for the cycle after the strobe
      @(posedge clk);
      d = ioRdData;
   endtask

   // Single caller only, so the shared byte is never interleaved
   task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
      wr(lo + 6'h01, v[15:8]);
      wr(lo, v[7:0]);
   endtask

   task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
      logic [7:0] l;
      logic [7:0] h;
      // Low then high strobes back to back
      @(posedge clk);
      ioAddr <= lo;
      ioRd <= 1'b1;
      @(posedge clk);
      ioAddr <= lo + 6'h01;
      @(posedge clk);
      l = ioRdData;
      ioRd <= 1'b0;
      ioAddr <= ~(lo + 6'h01);
      @(posedge clk);
      h = ioRdData;
      v = {h, l};
   endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "timer16_defines.svh"
module tb;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [5:0]  ioAddr;
   logic [7:0]  ioWrData;
   logic        ioWr;
   logic        ioRd;
   logic [7:0]  ioRdData;
   logic [1:0]  pwmSelect = 2'h0;
   logic        capturePin = 1'b0;
   logic        externalCountPin = 1'b0;
   logic        compareAFlag;
   logic        compareBFlag;
   logic        captureFlag;
   logic [15:0] captureValue;
   logic        extRun = 1'b0;
   int          err_total = 0;
   int          check_count = 0;
   int          cyc = 0;
   int          nA = 0;
   int          nB = 0;
   int          lastA = 0;
   int          gapA = 0;
   int          nCap = 0;
   logic [5:0]  rstAddr [6] = '{`ADDR_CMPB_LO, `ADDR_CMPB_HI, `ADDR_CMPA_LO,
                                `ADDR_CMPA_HI, `ADDR_CTRLB, 6'h3F};
   logic [6:0]  capTab [5] = '{7'h25, 7'h05, 7'h64, 7'h71, 7'h51};

   always #10 clk = ~clk;

   timer16_cpu_model cpu_i (.clk(clk), .ioAddr(ioAddr), .ioWrData(ioWrData),
      .ioWr(ioWr), .ioRd(ioRd), .ioRdData(ioRdData));

   timer16_capture_compare_core timer16_capture_compare_core_i (.clk(clk), .rstn(rstn),
      .ioAddr(ioAddr), .ioWrData(ioWrData), .ioWr(ioWr), .ioRd(ioRd),
      .ioRdData(ioRdData), .pwmSelect(pwmSelect), .capturePin(capturePin),
      .externalCountPin(externalCountPin), .compareAFlag(compareAFlag),
      .compareBFlag(compareBFlag), .captureFlag(captureFlag),
      .captureValue(captureValue));

   // ****************************************************************
   // Event counters and external count pin
   // ****************************************************************
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (compareAFlag === 1'b1)
      begin
         nA <= nA + 1;
         gapA <= cyc - lastA;
         lastA <= cyc;
      end
      if (compareBFlag === 1'b1)
         nB <= nB + 1;
      if (captureFlag === 1'b1)
         nCap <= nCap + 1;
      if (extRun)
         externalCountPin <= (cyc % 10) < 5;
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask

   function automatic int div_of(input logic [2:0] cs);
      case (cs)
         `CS_DIV1: return 1;
         `CS_DIV8: return 8;
         `CS_DIV64: return 64;
         `CS_DIV256: return 256;
         `CS_DIV1024: return 1024;
         `CS_EXT_FALL, `CS_EXT_RISE: return 10;
         default: return 0;
      endcase
   endfunction

   function automatic logic [15:0] top_of(input logic [1:0] m);
      case (m)
         `PWM_8: return `TOP_8;
         `PWM_9: return `TOP_9;
         default: return `TOP_10;
      endcase
   endfunction

   task automatic run_ctc(input logic [2:0] cs, input logic ctc, input int c,
                          output int n, output int g);
      int base;
      cpu_i.wr(`ADDR_CTRLB, 8'h00);
      cpu_i.wr16(`ADDR_CMPA_LO, 16'(c));
      cpu_i.wr16(`ADDR_CNT_LO, 16'h0000);
      base = nA;
      cpu_i.wr(`ADDR_CTRLB, {4'h0, ctc, cs});
      repeat (3 * (c + 1) * div_of(cs) + 40) @(posedge clk);
      n = nA - base;
      g = gapA;
   endtask

   task automatic print_verdict();
      if (err_total == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial
   begin
      logic [7:0]  b;
      logic [7:0]  h;
      logic [15:0] v;
      logic [15:0] w;
      logic [5:0]  lo;
      logic [6:0]  e;
      int          n;
      int          g;
      int          c;
      void'($urandom(55));
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (rstAddr[i])
      begin
         cpu_i.rd(rstAddr[i], b);
         chk({8'h00, b}, 16'h0000);
      end
      b = 8'($urandom);
      cpu_i.wr(`ADDR_CTRLB, b);
      cpu_i.rd(`ADDR_CTRLB, h);
      chk({8'h00, h}, {8'h00, b & 8'hCF});
      cpu_i.wr(`ADDR_CTRLB, 8'h00);
      for (int i = 0; i < 2; i++)
      begin
         lo = (i == 0) ? `ADDR_CMPA_LO : `ADDR_CMPB_LO;
         v = 16'($urandom);
         cpu_i.wr16(lo, v);
         cpu_i.rd(lo, b);
         cpu_i.rd(lo + 6'h01, h);
         chk({h, b}, v);
      end
      v = 16'($urandom);
      cpu_i.wr16(`ADDR_CNT_LO, v);
      cpu_i.rd16(`ADDR_CNT_LO, w);
      chk(w, v);
      cpu_i.rd(`ADDR_CNT_LO, b);
      cpu_i.wr(`ADDR_CTRLB, {5'h00, `CS_DIV1});
      repeat (600) @(posedge clk);
      cpu_i.rd(`ADDR_CNT_HI, h);
      chk({8'h00, h}, {8'h00, v[15:8]});
      c = 2 + int'($urandom & 1);
      for (int cs = 1; cs < 8; cs++)
      begin
         extRun <= (cs >= 6);
         run_ctc(3'(cs), 1'b1, c, n, g);
         chk(16'(n >= 2), 16'h0001);
         chk(16'(g), 16'((c + 1) * div_of(3'(cs))));
      end
      extRun <= 1'b0;
      run_ctc(`CS_STOP, 1'b1, c, n, g);
      chk(16'(n), 16'h0000);
      run_ctc(`CS_DIV1, 1'b0, c, n, g);
      chk(16'(n), 16'h0001);
      cpu_i.wr(`ADDR_CTRLB, 8'h00);
      v = 16'h0100 + 16'($urandom & 32'h0FFF);
      cpu_i.wr16(`ADDR_CMPA_LO, v);
      cpu_i.wr16(`ADDR_CMPB_LO, v);
      cpu_i.wr16(`ADDR_CNT_LO, 16'h0000);
      cpu_i.wr(`ADDR_CTRLB, {5'h00, `CS_DIV1});
      n = nA;
      g = nB;
      cpu_i.wr16(`ADDR_CNT_LO, v);
      repeat (20) @(posedge clk);
      chk(16'(nA - n), 16'h0000);
      chk(16'(nB - g), 16'h0000);
      n = nA;
      g = nB;
      cpu_i.wr16(`ADDR_CNT_LO, v - 16'h0001);
      repeat (8) @(posedge clk);
      chk(16'(nA - n), 16'h0001);
      chk(16'(nB - g), 16'h0001);
      cpu_i.wr(`ADDR_CTRLB, 8'h00);
      v = 16'($urandom);
      cpu_i.wr16(`ADDR_CNT_LO, v);
      foreach (capTab[i])
      begin
         e = capTab[i];
         cpu_i.wr(`ADDR_CTRLB, {e[6:5], 6'h00});
         n = nCap;
         capturePin <= 1'b1;
         repeat (e[4:1]) @(posedge clk);
         capturePin <= 1'b0;
         repeat (20) @(posedge clk);
         chk(16'(nCap - n), {15'h0000, e[0]});
         chk(captureValue, v);
      end
      for (int m = 1; m < 4; m++)
      begin
         pwmSelect <= 2'(m);
         w = top_of(2'(m));
         run_ctc(`CS_DIV1, 1'b1, c, n, g);
         chk(16'(n), 16'h0001);
         run_ctc(`CS_DIV1, 1'b1, int'(w), n, g);
         chk(16'(g), w << 1);
      end
      print_verdict();
   end

   initial
   begin
      #1_200_000;
      err_total++;
      print_verdict();
   end
endmodule
`default_nettype wire
